//--- verilog/pcpi_pkg.sv
// constants, register map and carrier types of the position-complete block
// assumes one 25 MHz clock and a plain register port of 16-bit words
// How it works
// RULE_01: in position control the completion output is driven low while the error magnitude is below the width, and high otherwise.
// RULE_02: the completion width takes only values from 0 to 250, in command units.
// RULE_03: the width is compared with the error counted in command units, before any gear scaling.
// RULE_04: the completion level can be routed to another output terminal chosen by an assignment setting.
// RULE_05: a new width is applied only while the completion output is asserted and never touches loop accuracy; here also outside position control.
// RULE_06: the jitter frequency setting takes 10 to 1000 in 0.1 Hz steps and resets to 1000.
// RULE_07: the jitter damping setting takes 0 to 200, has no unit and resets to 25.
// RULE_08: jitter compensation is enabled only for frequencies from 5.0 Hz to 50.0 Hz.
// RULE_09: the operator raises damping only if the motor keeps vibrating at standstill.
// RULE_10: while the inhibit input is low in position control, command pulses are not counted; counting resumes when it goes high.
// RULE_11: while counting is inhibited the servo is held locked at its present position.
// RULE_12: the error is a signed count of command minus feedback pulses, its magnitude compared every cycle.
package pcpi_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] WIDTH_OFS  = 8'h04;
   localparam logic [7:0] OSEL_OFS   = 8'h08;
   localparam logic [7:0] FREQ_OFS   = 8'h0C;
   localparam logic [7:0] DAMP_OFS   = 8'h10;
   localparam logic [7:0] ERR_OFS    = 8'h14;
   localparam logic [7:0] STAT_OFS   = 8'h18;
   localparam logic [7:0] MASK_OFS   = 8'h1C;
   localparam logic [7:0] INFO_OFS   = 8'h20;

   // control fields
   localparam int CTRL_POS_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;

   // setting limits and reset values
   localparam logic [15:0] WIDTH_MAX = 16'h00FA;
   localparam logic [15:0] FREQ_MIN  = 16'h000A;
   localparam logic [15:0] FREQ_MAX  = 16'h03E8;
   localparam logic [15:0] FREQ_RST  = 16'h03E8;
   localparam logic [15:0] DAMP_MAX  = 16'h00C8;
   localparam logic [15:0] DAMP_RST  = 16'h0019;
   localparam logic [15:0] BAND_LO   = 16'h0032;
   localparam logic [15:0] BAND_HI   = 16'h01F4;

   // output terminals
   localparam int NUM_OUT = 4;
   localparam int OSEL_W  = 2;
   localparam logic [1:0] OSEL_RST = 2'h0;

   // status and mask bits
   localparam int EV_DONE   = 0;
   localparam int EV_UNDONE = 1;
   localparam int EV_INH    = 2;
   localparam int EV_REJ    = 3;
   localparam int NUM_EV    = 4;

   typedef struct packed {
      logic step;
      logic dir;
   } pcpi_pulse_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } pcpi_bus_type;
endpackage : pcpi_pkg

//--- verilog/pcpi_irq.sv
// sticky event status, mask and level interrupt
// assumes events are one-cycle pulses; a write of one clears a bit
module pcpi_irq #(
   parameter int N = 4
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // events and software access
   input  wire logic [N-1:0] event_pulse,
   input  wire logic         stat_wr,
   input  wire logic         mask_wr,
   input  wire logic [N-1:0] wr_bits,
   // state
   output logic      [N-1:0] status,
   output logic      [N-1:0] mask,
   output logic              irq
);
   // set wins over clear so no event is lost
   always_ff @(posedge core_clk) begin
      if (rst) begin
         status <= '0;
      end else if (stat_wr) begin
         status <= (status & ~wr_bits) | event_pulse;
      end else begin
         status <= status | event_pulse;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mask <= '0;
      end else if (mask_wr) begin
         mask <= wr_bits;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end
endmodule : pcpi_irq

//--- verilog/pcpi_err_cnt.sv
// signed position error counter in command units
// assumes cmd and fb steps are one-cycle pulses, already decoded
module pcpi_err_cnt #(
   parameter int ERR_W = 24
) (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // pulses
   input  wire pcpi_pkg::pcpi_pulse_type cmd,
   input  wire pcpi_pkg::pcpi_pulse_type fb,
   input  wire logic                  count_en,
   input  wire logic                  clear,
   // count
   output logic signed [ERR_W-1:0]    err,
   output logic        [ERR_W-1:0]    mag
);
   localparam logic signed [ERR_W-1:0] MAXV = {1'b0, {(ERR_W-1){1'b1}}};

   logic signed [1:0]       cmd_d;
   logic signed [1:0]       fb_d;
   logic signed [ERR_W+1:0] sum;
   logic signed [ERR_W-1:0] err_next;

   always_comb begin
      cmd_d = 2'sd0;
      fb_d  = 2'sd0;
      if (cmd.step && count_en) begin                            // RULE_10
         cmd_d = cmd.dir ? 2'sd1 : -2'sd1;
      end
      if (fb.step) begin
         fb_d = fb.dir ? 2'sd1 : -2'sd1;
      end
      sum = (ERR_W+2)'(err) + (ERR_W+2)'(cmd_d) - (ERR_W+2)'(fb_d); // RULE_12
      // saturate symmetrically so the magnitude always fits
      if (sum > (ERR_W+2)'(MAXV)) begin
         err_next = MAXV;
      end else if (sum < -(ERR_W+2)'(MAXV)) begin
         err_next = -MAXV;
      end else begin
         err_next = sum[ERR_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || clear) begin
         err <= '0;
         mag <= '0;
      end else begin
         err <= err_next;
         mag <= err_next[ERR_W-1] ? ERR_W'(-err_next) : ERR_W'(err_next);
      end
   end

   cmd_step_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
      (count_en && cmd.step && cmd.dir && !fb.step && !clear
       && err < MAXV) |=> (err == $past(err) + 2'sd1))
      else $error("command pulse not counted as one unit");

   inhibit_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_10
      (!count_en && !fb.step && !clear) |=> $stable(err))
      else $error("error moved while counting inhibited");

   mag_match_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_12
      mag == (err[ERR_W-1] ? ERR_W'(-err) : ERR_W'(err)))
      else $error("magnitude does not match signed error");
endmodule : pcpi_err_cnt

//--- verilog/pcpi_top.sv
// position completion, pulse inhibit and jitter settings of a servo drive
// assumes decoded one-cycle command and feedback pulses in command units
//
// The placing of the registers and strobed register access were decided locally.
module pcpi_top #(
   parameter int          ERR_W     = 24,
   parameter logic [15:0] WIDTH_RST = 16'h0007
) (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   // register port
   input  wire pcpi_pkg::pcpi_bus_type    bus,
   output logic [pcpi_pkg::DATA_W-1:0]    rd_data,
   // pulses and inhibit
   input  wire pcpi_pkg::pcpi_pulse_type  cmd,
   input  wire pcpi_pkg::pcpi_pulse_type  fb,
   input  wire logic                      inhibit_n,
   // completion outputs
   output logic                           position_done_n,
   output logic [pcpi_pkg::NUM_OUT-1:0]   out_term,
   output logic                           servo_lock,
   // jitter suppression settings
   output logic [15:0]                    jitter_freq,
   output logic [15:0]                    jitter_damp,
   output logic                           jitter_active,
   // monitor and interrupt
   output logic [ERR_W-1:0]               position_error_monitor,
   output logic                           irq
);
   logic                         pos_mode_reg;
   logic                         err_clear_reg;
   logic [15:0]                  width_reg;
   logic [15:0]                  width_pend_reg;
   logic                         pend_valid_reg;
   logic [pcpi_pkg::OSEL_W-1:0]  out_sel_reg;
   logic [15:0]                  freq_reg;
   logic [15:0]                  damp_reg;
   logic                         active_reg;
   logic                         done_n_reg;
   logic                         lock_reg;
   logic [pcpi_pkg::NUM_OUT-1:0] term_reg;
   logic [pcpi_pkg::DATA_W-1:0]  rd_data_reg;
   logic                         done_n_next;
   logic                         lock_next;
   logic                         count_en;
   logic                         wr_ok;
   logic                         rej_next;
   logic signed [ERR_W-1:0]      err;
   logic [ERR_W-1:0]             err_mag;
   logic [pcpi_pkg::NUM_EV-1:0]  ev;
   logic [pcpi_pkg::NUM_EV-1:0]  status;
   logic [pcpi_pkg::NUM_EV-1:0]  mask;
   logic                         irq_int;
   logic                         stat_wr;
   logic                         mask_wr;

   // write decode and range checks
   always_comb begin
      wr_ok    = 1'b0;
      rej_next = 1'b0;
      if (bus.wr) begin
         case (bus.addr)
            pcpi_pkg::WIDTH_OFS: begin
               wr_ok = bus.wdata <= pcpi_pkg::WIDTH_MAX;       // RULE_02
            end
            pcpi_pkg::FREQ_OFS: begin
               wr_ok = bus.wdata >= pcpi_pkg::FREQ_MIN
                    && bus.wdata <= pcpi_pkg::FREQ_MAX;        // RULE_06
            end
            pcpi_pkg::DAMP_OFS: begin
               wr_ok = bus.wdata <= pcpi_pkg::DAMP_MAX;        // RULE_07
            end
            pcpi_pkg::OSEL_OFS: begin
               wr_ok = bus.wdata < 16'(pcpi_pkg::NUM_OUT);
            end
            default: begin
               wr_ok = 1'b1;
            end
         endcase
         rej_next = !wr_ok;
      end
   end

   assign stat_wr = bus.wr && bus.addr == pcpi_pkg::STAT_OFS;
   assign mask_wr = bus.wr && bus.addr == pcpi_pkg::MASK_OFS;

   // control register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pos_mode_reg  <= 1'b0;
         err_clear_reg <= 1'b0;
      end else begin
         err_clear_reg <= 1'b0;
         if (bus.wr && bus.addr == pcpi_pkg::CTRL_OFS) begin
            pos_mode_reg  <= bus.wdata[pcpi_pkg::CTRL_POS_BIT];
            err_clear_reg <= bus.wdata[pcpi_pkg::CTRL_CLR_BIT];
         end
      end
   end

   // completion width: a write waits until completion is asserted or position control is off
   // so a tighter window cannot break an interlock mid-move
   always_ff @(posedge core_clk) begin
      if (rst) begin
         width_pend_reg <= WIDTH_RST;
         pend_valid_reg <= 1'b0;
      end else if (bus.wr && bus.addr == pcpi_pkg::WIDTH_OFS && wr_ok) begin
         width_pend_reg <= bus.wdata;
         pend_valid_reg <= 1'b1;
      end else if (pend_valid_reg && (!done_n_reg || !pos_mode_reg)) begin
         pend_valid_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         width_reg <= WIDTH_RST;
      end else if (pend_valid_reg && (!done_n_reg || !pos_mode_reg)) begin
         width_reg <= width_pend_reg;                          // RULE_05
      end
   end

   // output assignment
   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_sel_reg <= pcpi_pkg::OSEL_RST;
      end else if (bus.wr && bus.addr == pcpi_pkg::OSEL_OFS && wr_ok) begin
         out_sel_reg <= bus.wdata[pcpi_pkg::OSEL_W-1:0];       // RULE_04
      end
   end

   // jitter suppression settings; the algorithm itself lives elsewhere
   always_ff @(posedge core_clk) begin
      if (rst) begin
         freq_reg <= pcpi_pkg::FREQ_RST;
      end else if (bus.wr && bus.addr == pcpi_pkg::FREQ_OFS && wr_ok) begin
         freq_reg <= bus.wdata;                                // RULE_06
      end
   end

   // damping is left at reset unless standstill vibration persists
   always_ff @(posedge core_clk) begin
      if (rst) begin
         damp_reg <= pcpi_pkg::DAMP_RST;
      end else if (bus.wr && bus.addr == pcpi_pkg::DAMP_OFS && wr_ok) begin
         damp_reg <= bus.wdata;                                // RULE_07
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         active_reg <= 1'b0;
      end else begin
         active_reg <= freq_reg >= pcpi_pkg::BAND_LO
                    && freq_reg <= pcpi_pkg::BAND_HI;          // RULE_08
      end
   end

   // inhibit gates counting only in position control
   assign lock_next = pos_mode_reg && !inhibit_n;              // RULE_11
   assign count_en  = !lock_next;                              // RULE_10

   pcpi_err_cnt #(
      .ERR_W    (ERR_W)
   ) u_err (
      .core_clk (core_clk),
      .rst      (rst),
      .cmd      (cmd),
      .fb       (fb),
      .count_en (count_en),
      .clear    (err_clear_reg),
      .err      (err),
      .mag      (err_mag)
   );

   always_ff @(posedge core_clk) begin
      if (rst) begin
         lock_reg <= 1'b0;
      end else begin
         lock_reg <= lock_next;                                // RULE_11
      end
   end

   // compare uses command units, ungeared
   assign done_n_next = !(pos_mode_reg
                       && err_mag < ERR_W'(width_reg));        // RULE_01 RULE_03

   always_ff @(posedge core_clk) begin
      if (rst) begin
         done_n_reg <= 1'b1;
      end else begin
         done_n_reg <= done_n_next;                            // RULE_01
      end
   end

   // unselected terminals sit at the inactive high level
   genvar gi;
   generate
      for (gi = 0; gi < pcpi_pkg::NUM_OUT; gi++) begin : g_term
         always_ff @(posedge core_clk) begin
            if (rst) begin
               term_reg[gi] <= 1'b1;
            end else begin
               term_reg[gi] <= (out_sel_reg == pcpi_pkg::OSEL_W'(gi))
                             ? done_n_next : 1'b1;             // RULE_04
            end
         end
      end
   endgenerate

   // events
   always_comb begin
      ev                      = '0;
      ev[pcpi_pkg::EV_DONE]   = done_n_reg && !done_n_next;
      ev[pcpi_pkg::EV_UNDONE] = !done_n_reg && done_n_next;
      ev[pcpi_pkg::EV_INH]    = !lock_reg && lock_next;
      ev[pcpi_pkg::EV_REJ]    = rej_next;
   end

   pcpi_irq #(
      .N           (pcpi_pkg::NUM_EV)
   ) u_irq (
      .core_clk    (core_clk),
      .rst         (rst),
      .event_pulse (ev),
      .stat_wr     (stat_wr),
      .mask_wr     (mask_wr),
      .wr_bits     (bus.wdata[pcpi_pkg::NUM_EV-1:0]),
      .status      (status),
      .mask        (mask),
      .irq         (irq_int)
   );

   // read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (rst || !bus.rd) begin
         rd_data_reg <= '0;
      end else begin
         case (bus.addr)
            pcpi_pkg::CTRL_OFS:  rd_data_reg <= 16'(pos_mode_reg);
            pcpi_pkg::WIDTH_OFS: rd_data_reg <= width_reg;
            pcpi_pkg::OSEL_OFS:  rd_data_reg <= 16'(out_sel_reg);
            pcpi_pkg::FREQ_OFS:  rd_data_reg <= freq_reg;
            pcpi_pkg::DAMP_OFS:  rd_data_reg <= damp_reg;
            pcpi_pkg::ERR_OFS:   rd_data_reg <= err[15:0];
            pcpi_pkg::STAT_OFS:  rd_data_reg <= 16'(status);
            pcpi_pkg::MASK_OFS:  rd_data_reg <= 16'(mask);
            pcpi_pkg::INFO_OFS:  rd_data_reg <= {12'h000, active_reg,
                                    pend_valid_reg, lock_reg, done_n_reg};
            default:             rd_data_reg <= '0;
         endcase
      end
   end

   assign rd_data                = rd_data_reg;
   assign position_done_n        = done_n_reg;
   assign out_term               = term_reg;
   assign servo_lock             = lock_reg;
   assign jitter_freq            = freq_reg;
   assign jitter_damp            = damp_reg;
   assign jitter_active          = active_reg;
   assign position_error_monitor = err;
   assign irq                    = irq_int;

   done_cause_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_01
      !done_n_reg |-> $past(pos_mode_reg && err_mag < ERR_W'(width_reg)))
      else $error("completion asserted without cause");

   done_set_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_12
      (pos_mode_reg && err_mag < ERR_W'(width_reg)) |=> !done_n_reg)
      else $error("completion missed with small error");

   width_range_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_02
      width_reg <= pcpi_pkg::WIDTH_MAX)
      else $error("width out of range");

   route_term_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_04
      ##1 term_reg[$past(out_sel_reg)] == done_n_reg)
      else $error("selected terminal differs from completion");

   width_hold_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_05
      $changed(width_reg) |-> $past(!done_n_reg || !pos_mode_reg))
      else $error("width changed while not complete");

   freq_range_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_06
      freq_reg >= pcpi_pkg::FREQ_MIN && freq_reg <= pcpi_pkg::FREQ_MAX)
      else $error("jitter frequency out of range");

   damp_range_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_07
      damp_reg <= pcpi_pkg::DAMP_MAX)
      else $error("damping out of range");

   band_gate_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_08
      ##1 active_reg == ($past(freq_reg) >= pcpi_pkg::BAND_LO
                         && $past(freq_reg) <= pcpi_pkg::BAND_HI))
      else $error("compensation enable wrong for band");

   lock_follow_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_11
      (pos_mode_reg && !inhibit_n) [*2] |-> lock_reg)
      else $error("servo not locked during inhibit");

   reject_flag_a: assert property (@(posedge core_clk) disable iff (rst) // RULE_02
      (bus.wr && bus.addr == pcpi_pkg::WIDTH_OFS
       && bus.wdata > pcpi_pkg::WIDTH_MAX) |=> status[pcpi_pkg::EV_REJ])
      else $error("rejected write not flagged");
endmodule : pcpi_top

//--- dv/pcpi_host_model.sv
// host controller model: bursts of one-cycle command steps
// assumes the bench asks for a burst only while busy is low
module pcpi_host_model (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   // burst request
   input  wire logic                 start,
   input  wire logic [7:0]           num,
   input  wire logic                 fwd,
   // pulse train
   output pcpi_pkg::pcpi_pulse_type  cmd,
   output logic                      busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left_reg;
   logic       dir_reg;

   assign busy = (left_reg != 8'h00) || cmd.step;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         left_reg <= 8'h00;
         dir_reg  <= 1'b0;
      end else if (start && !busy) begin
         left_reg <= num;
         dir_reg  <= fwd;
      end else if (left_reg != 8'h00) begin
         left_reg <= left_reg - 8'h01;
      end
   end

   // idle direction toggles so nothing rides on a stale level
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmd <= '0;
      end else if (left_reg != 8'h00) begin
         cmd.step <= 1'b1;
         cmd.dir  <= dir_reg;
      end else begin
         cmd.step <= 1'b0;
         cmd.dir  <= ~cmd.dir;
      end
   end
endmodule : pcpi_host_model

//--- dv/pcpi_top_test.sv
// self-checking bench of the position-complete block
// assumes the host model drives commands; the bench drives bus and feedback
module pcpi_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                      core_clk = 1'b0;
   logic                      rst = 1'b1;
   pcpi_pkg::pcpi_bus_type    bus = '0;
   pcpi_pkg::pcpi_pulse_type  cmd;
   pcpi_pkg::pcpi_pulse_type  fb = '0;
   logic                      inhibit_n = 1'b1;
   logic                      start = 1'b0;
   logic [7:0]                num = 8'h00;
   logic                      fwd = 1'b0;
   logic                      busy;
   logic [15:0]               rd_data;
   logic                      done_n;
   logic [3:0]                out_term;
   logic                      servo_lock;
   logic [15:0]               jfreq;
   logic [15:0]               jdamp;
   logic                      jact;
   logic [23:0]               err_mon;
   logic                      irq;
   logic [15:0]               d;
   int                        miscompares = 0;
   int                        compares = 0;

   always #20 core_clk = ~core_clk;

   pcpi_host_model host (.core_clk(core_clk), .rst(rst), .start(start),
      .num(num), .fwd(fwd), .cmd(cmd), .busy(busy));

   pcpi_top dut (.core_clk(core_clk), .rst(rst), .bus(bus),
      .rd_data(rd_data), .cmd(cmd), .fb(fb), .inhibit_n(inhibit_n),
      .position_done_n(done_n), .out_term(out_term),
      .servo_lock(servo_lock), .jitter_freq(jfreq), .jitter_damp(jdamp),
      .jitter_active(jact), .position_error_monitor(err_mon), .irq(irq));

   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task wait_n(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wait_n

   task wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge core_clk);
      bus.addr  <= a;
      bus.wdata <= v;
      bus.wr    <= 1'b1;
      @(posedge core_clk);
      bus.wr    <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a);
      @(posedge core_clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge core_clk);
      bus.rd   <= 1'b0;
      #1 d = rd_data;
   endtask : rd

   task send(input logic [7:0] n, input logic f);
      @(posedge core_clk);
      start <= 1'b1;
      num   <= n;
      fwd   <= f;
      @(posedge core_clk);
      start <= 1'b0;
      #1;
      for (int i = 0; i < 300 && busy; i++) @(posedge core_clk);
      wait_n(3);
   endtask : send

   task fb_step(input logic f);
      @(posedge core_clk);
      fb <= '{step: 1'b1, dir: f};
      @(posedge core_clk);
      fb <= '0;
      wait_n(3);
   endtask : fb_step

   task t_reset;
      chk(jfreq, 16'h03E8);
      chk(jdamp, 16'h0019);
      chk(16'(done_n), 16'h0001);
      chk(16'(out_term), 16'h000F);
      rd(8'h0C);
      chk(d, 16'h03E8);
      rd(8'h40);
      chk(d, 16'h0000);
      $display("test reset finished");
   endtask : t_reset

   task t_done;
      wr(8'h00, 16'h0003);
      wait_n(4);
      chk(16'(done_n), 16'h0000);
      chk(16'(out_term), 16'h000E);
      send(8'h07, 1'b1);
      chk(err_mon[15:0], 16'h0007);
      chk(16'(done_n), 16'h0001);
      fb_step(1'b1);
      chk(err_mon[15:0], 16'h0006);
      chk(16'(done_n), 16'h0000);
      wr(8'h08, 16'h0002);
      wait_n(3);
      chk(16'(out_term), 16'h000B);
      send(8'h03, 1'b0);
      chk(err_mon[15:0], 16'h0003);
      $display("test completion finished");
   endtask : t_done

   task t_width;
      wr(8'h00, 16'h0003);
      send(8'h09, 1'b1);
      wr(8'h04, 16'h0014);
      wait_n(4);
      chk(16'(done_n), 16'h0001);
      rd(8'h20);
      chk(d, 16'h0005);
      repeat (3) fb_step(1'b1);
      chk(16'(done_n), 16'h0000);
      rd(8'h04);
      chk(d, 16'h0014);
      send(8'h0A, 1'b1);
      chk(err_mon[15:0], 16'h0010);
      chk(16'(done_n), 16'h0000);
      $display("test width finished");
   endtask : t_width

   task t_reject;
      wr(8'h1C, 16'h0000);
      wr(8'h18, 16'h000F);
      wr(8'h04, 16'h00FB);
      rd(8'h18);
      chk({15'h0000, d[3]}, 16'h0001);
      chk(16'(irq), 16'h0000);
      wr(8'h1C, 16'h0008);
      wait_n(3);
      chk(16'(irq), 16'h0001);
      wr(8'h18, 16'h0008);
      wait_n(3);
      chk(16'(irq), 16'h0000);
      wr(8'h04, 16'h00FA);
      rd(8'h18);
      chk({15'h0000, d[3]}, 16'h0000);
      wr(8'h00, 16'h0003);
      wr(8'h04, 16'h0000);
      wait_n(5);
      chk(16'(done_n), 16'h0001);
      $display("test reject finished");
   endtask : t_reject

   task t_inhibit;
      wr(8'h00, 16'h0003);
      wr(8'h18, 16'h000F);
      @(posedge core_clk);
      inhibit_n <= 1'b0;
      wait_n(2);
      chk(16'(servo_lock), 16'h0001);
      rd(8'h18);
      chk({15'h0000, d[2]}, 16'h0001);
      send(8'h05, 1'b1);
      chk(err_mon[15:0], 16'h0000);
      @(posedge core_clk);
      inhibit_n <= 1'b1;
      wait_n(2);
      chk(16'(servo_lock), 16'h0000);
      send(8'h05, 1'b1);
      chk(err_mon[15:0], 16'h0005);
      rd(8'h14);
      chk(d, 16'h0005);
      rd(8'h20);
      chk(d, 16'h0001);
      $display("test inhibit finished");
   endtask : t_inhibit

   task t_jitter;
      logic [15:0] fv [7];
      logic [15:0] fe [7];
      logic        ae [7];
      fv = '{16'h012C, 16'h0009, 16'h000A, 16'h0032, 16'h01F4, 16'h01F5,
             16'h03E9};
      fe = '{16'h012C, 16'h012C, 16'h000A, 16'h0032, 16'h01F4, 16'h01F5,
             16'h01F5};
      ae = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 7; i++) begin
         wr(8'h0C, fv[i]);
         wait_n(3);
         chk(jfreq, fe[i]);
         chk(16'(jact), 16'(ae[i]));
      end
      wr(8'h10, 16'h00C9);
      wait_n(2);
      chk(jdamp, 16'h0019);
      // damping raised only for standstill vibration
      wr(8'h10, 16'h00C8);
      wait_n(2);
      chk(jdamp, 16'h00C8);
      $display("test jitter finished");
   endtask : t_jitter

   task give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   initial begin
      #(40 * 5000);
      miscompares++;
      give_verdict();
   end

   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      wait_n(2);
      t_reset();
      t_done();
      t_width();
      t_reject();
      t_inhibit();
      t_jitter();
      give_verdict();
   end
endmodule : pcpi_top_test
